// >>> drc_ctrl.sv
// Host-side controller that drives reads, writes, read-modify-writes and row refresh on the RAM pins
module drc_ctrl
    import drc_pkg::*;
#(
    parameter int REFRESH_SWEEP = REFRESH_SWEEP_CYC,
    parameter int STANDBY_LIMIT = STANDBY_LIMIT_CYC
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // Request port
    input wire logic i_req_valid,
    output logic o_req_ready,
    input wire drc_cmd_t i_req_cmd,
    input wire logic [ADDR_W-1:0] i_req_addr,
    input wire logic i_req_wdata,
    input wire logic i_req_wmask,
    // Answer port
    output logic o_rsp_valid,
    output logic o_rsp_rdata,
    // Standby control
    input wire logic i_standby_req,
    output logic o_standby,
    output logic o_data_trusted,
    // Memory pins
    output logic [ROW_W-1:0] o_row_addr,
    output logic [COL_W-1:0] o_col_addr,
    output logic o_rw,
    output logic o_ce_n,
    output logic o_din,
    input wire logic i_dout
);
    drc_state_t state_r, state_nxt;
    drc_cmd_t cmd_r, cmd_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic din_r, din_nxt;
    logic mask_r, mask_nxt;
    logic rw_r, rw_nxt;
    logic ce_n_r, ce_n_nxt;
    logic rsp_valid_r, rsp_valid_nxt;
    logic rdata_r, rdata_nxt;
    logic refresh_r, refresh_nxt;
    logic [ROW_W-1:0] ref_row_r, ref_row_nxt;
    logic sweep_due_r, sweep_due_nxt;
    logic trusted_r, trusted_nxt;
    logic stby_long_r, stby_long_nxt;
    logic wait_load;
    logic [TIMER_W-1:0] wait_val;
    logic wait_done;
    logic sweep_load;
    logic sweep_done;
    logic stby_load;
    logic stby_done;

    drc_timer #(.WIDTH(TIMER_W)) u_wait (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_load(wait_load),
        .i_value(wait_val),
        .o_done(wait_done)
    );

    // Sweep period; each row is revisited once per sweep, well inside its interval
    drc_timer #(.WIDTH(TIMER_W)) u_sweep (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_load(sweep_load),
        .i_value(TIMER_W'(REFRESH_SWEEP)),
        .o_done(sweep_done)
    );

    drc_timer #(.WIDTH(TIMER_W)) u_stby (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_load(stby_load),
        .i_value(TIMER_W'(STANDBY_LIMIT)),
        .o_done(stby_done)
    );

    assign o_req_ready = (state_r == DRC_IDLE) && !sweep_due_r && !i_standby_req && trusted_r;
    assign sweep_load = sweep_done;

    always_comb begin
        state_nxt = state_r;
        cmd_nxt = cmd_r;
        addr_nxt = addr_r;
        din_nxt = din_r;
        mask_nxt = mask_r;
        rw_nxt = rw_r;
        ce_n_nxt = ce_n_r;
        rsp_valid_nxt = 1'b0;
        rdata_nxt = rdata_r;
        refresh_nxt = refresh_r;
        ref_row_nxt = ref_row_r;
        sweep_due_nxt = sweep_due_r || sweep_done;
        trusted_nxt = trusted_r;
        stby_long_nxt = stby_long_r;
        wait_load = 1'b0;
        wait_val = '0;
        stby_load = 1'b0;
        case (state_r)
            DRC_IDLE: begin
                if (sweep_due_r) begin
                    // Dedicated refresh: write-like cycle with enable high
                    refresh_nxt = 1'b1;
                    ce_n_nxt = 1'b1;
                    addr_nxt = {ref_row_r, COL_W'(0)};
                    wait_load = 1'b1;
                    wait_val = TIMER_W'(ADDR_TO_WRITE_CYC);
                    state_nxt = DRC_SETUP;
                end else if (i_standby_req) begin
                    ce_n_nxt = 1'b1;
                    stby_load = 1'b1;
                    stby_long_nxt = 1'b0;
                    state_nxt = DRC_STANDBY;
                end else if (i_req_valid && trusted_r) begin
                    cmd_nxt = i_req_cmd;
                    addr_nxt = i_req_addr;
                    din_nxt = i_req_wdata;
                    mask_nxt = i_req_wmask;
                    refresh_nxt = 1'b0;
                    ce_n_nxt = 1'b0;
                    rw_nxt = 1'b1;
                    wait_load = 1'b1;
                    if (i_req_cmd == DRC_CMD_WRITE) begin
                        wait_val = TIMER_W'(ADDR_TO_WRITE_CYC);
                        state_nxt = DRC_SETUP;
                    end else begin
                        wait_val = TIMER_W'(READ_ACCESS_CYC);
                        state_nxt = DRC_ACCESS;
                    end
                end
            end
            DRC_ACCESS: begin
                if (wait_done) begin
                    rdata_nxt = i_dout;
                    if (cmd_r == DRC_CMD_RMW) begin
                        state_nxt = DRC_MODIFY;
                    end else begin
                        rsp_valid_nxt = 1'b1;
                        ce_n_nxt = 1'b1;
                        wait_load = 1'b1;
                        wait_val = TIMER_W'(DISABLE_HOLD_CYC);
                        state_nxt = DRC_DISHOLD;
                    end
                end
            end
            DRC_MODIFY: begin
                // Modified value: flip the bit where the mask is set, pulse only after capture
                din_nxt = rdata_r ^ mask_r;
                rsp_valid_nxt = 1'b1;
                wait_load = 1'b1;
                wait_val = TIMER_W'(ADDR_TO_WRITE_CYC);
                state_nxt = DRC_SETUP;
            end
            DRC_SETUP: begin
                if (wait_done) begin
                    rw_nxt = 1'b0;
                    wait_load = 1'b1;
                    wait_val = TIMER_W'(WRITE_PULSE_CYC);
                    state_nxt = DRC_PULSE;
                end
            end
            DRC_PULSE: begin
                if (wait_done) begin
                    rw_nxt = 1'b1;
                    wait_load = 1'b1;
                    wait_val = TIMER_W'(WRITE_RECOVER_CYC);
                    state_nxt = DRC_RECOVER;
                end
            end
            DRC_RECOVER: begin
                // Address and data stay put until the cycle time is met
                if (wait_done) begin
                    if (refresh_r) begin
                        ref_row_nxt = ref_row_r + ROW_W'(1);
                        if (ref_row_r == ROW_LAST) begin
                            sweep_due_nxt = sweep_done;
                            refresh_nxt = 1'b0;
                            trusted_nxt = 1'b1;
                            state_nxt = DRC_IDLE;
                        end else begin
                            addr_nxt = {ref_row_nxt, COL_W'(0)};
                            wait_load = 1'b1;
                            wait_val = TIMER_W'(ADDR_TO_WRITE_CYC);
                            state_nxt = DRC_SETUP;
                        end
                    end else begin
                        ce_n_nxt = 1'b1;
                        wait_load = 1'b1;
                        wait_val = TIMER_W'(DISABLE_HOLD_CYC);
                        state_nxt = DRC_DISHOLD;
                    end
                end
            end
            DRC_STANDBY: begin
                if (stby_done) begin
                    stby_long_nxt = 1'b1;
                end
                if (!i_standby_req) begin
                    // A long standby loses retention: force a full sweep first
                    if (stby_long_r || stby_done) begin
                        trusted_nxt = 1'b0;
                        sweep_due_nxt = 1'b1;
                        ref_row_nxt = ROW_FIRST;
                    end
                    state_nxt = DRC_IDLE;
                end
            end
            DRC_DISHOLD: begin
                if (wait_done) begin
                    state_nxt = DRC_IDLE;
                end
            end
            default: begin
                state_nxt = DRC_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r <= DRC_IDLE;
            cmd_r <= DRC_CMD_READ;
            addr_r <= '0;
            din_r <= 1'b0;
            mask_r <= 1'b0;
            rw_r <= 1'b1;
            ce_n_r <= 1'b1;
            rsp_valid_r <= 1'b0;
            rdata_r <= 1'b0;
            refresh_r <= 1'b0;
            ref_row_r <= ROW_FIRST;
            sweep_due_r <= 1'b1;
            trusted_r <= 1'b0;
            stby_long_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cmd_r <= cmd_nxt;
            addr_r <= addr_nxt;
            din_r <= din_nxt;
            mask_r <= mask_nxt;
            rw_r <= rw_nxt;
            ce_n_r <= ce_n_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rdata_r <= rdata_nxt;
            refresh_r <= refresh_nxt;
            ref_row_r <= ref_row_nxt;
            sweep_due_r <= sweep_due_nxt;
            trusted_r <= trusted_nxt;
            stby_long_r <= stby_long_nxt;
        end
    end

    assign o_row_addr = addr_r[ADDR_W-1:COL_W];
    assign o_col_addr = addr_r[COL_W-1:0];
    assign o_rw = rw_r;
    assign o_ce_n = ce_n_r;
    assign o_din = din_r;
    assign o_rsp_valid = rsp_valid_r;
    assign o_rsp_rdata = rdata_r;
    assign o_standby = (state_r == DRC_STANDBY);
    assign o_data_trusted = trusted_r;
endmodule : drc_ctrl

// >>> drc_pkg.sv
// Package with timing constants, states and commands for the dynamic RAM access controller
// Function
// - Hold read/write strobe high during a read; device drives stored bit out.
// - Address may change once read data for current address is captured.
// - Every row must be rewritten at least once within each 2 ms.
// - Write by pulling strobe low with enable low and valid data in.
// - Keep address and data steady until strobe returns high after write.
// - Read-modify-write delays write pulse until read data captured and new value ready.
// - Refresh cycle equals write cycle but with chip enable held inactive.
// - Full refresh steps all 32 row addresses with one write pulse each.
// - After standby near 2 ms, restore supply then refresh before trusting data.
// - Refresh interval is measured per row address between its refresh cycles.
package drc_pkg;
    localparam int CLK_PERIOD_NS = 10;
    // Access and write timings of the slower speed grade, so both grades are served
    localparam int READ_ACCESS_NS = 500;
    localparam int ENABLE_TO_VALID_NS = 450;
    localparam int DISABLE_HOLD_NS = 450;
    localparam int ADDR_TO_WRITE_NS = 500;
    localparam int WRITE_PULSE_NS = 400;
    localparam int WRITE_CYCLE_NS = 900;
    localparam int ROW_REFRESH_INTERVAL_US = 2000;
    localparam int STANDBY_LIMIT_US = 2000;
    // Least times round up
    localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + ENABLE_TO_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ADDR_TO_WRITE_CYC = (ADDR_TO_WRITE_NS - WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_RECOVER_CYC = (WRITE_CYCLE_NS - ADDR_TO_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DISABLE_HOLD_CYC = (DISABLE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Longest time rounds down; a whole sweep must fit well inside it
    localparam int ROW_REFRESH_INTERVAL_CYC = ROW_REFRESH_INTERVAL_US * 1000 / CLK_PERIOD_NS;
    localparam int REFRESH_SWEEP_CYC = ROW_REFRESH_INTERVAL_CYC / 2;
    localparam int STANDBY_LIMIT_CYC = STANDBY_LIMIT_US * 1000 / CLK_PERIOD_NS;
    localparam int ROW_W = 5;
    localparam int COL_W = 5;
    localparam int ADDR_W = ROW_W + COL_W;
    localparam int NUM_ROWS = 32;
    localparam int TIMER_W = 24;
    localparam logic [ROW_W-1:0] ROW_LAST = 5'h1f;
    localparam logic [ROW_W-1:0] ROW_FIRST = 5'h00;

    typedef enum logic [1:0] {
        DRC_CMD_READ = 2'h0,
        DRC_CMD_WRITE = 2'h1,
        DRC_CMD_RMW = 2'h2
    } drc_cmd_t;

    typedef enum logic [7:0] {
        DRC_IDLE = 8'h01,
        DRC_ACCESS = 8'h02,
        DRC_MODIFY = 8'h04,
        DRC_SETUP = 8'h08,
        DRC_PULSE = 8'h10,
        DRC_RECOVER = 8'h20,
        DRC_STANDBY = 8'h40,
        DRC_DISHOLD = 8'h80
    } drc_state_t;
endpackage : drc_pkg

// >>> drc_timer.sv
// Down counter used for cycle waits and the refresh and standby deadlines
module drc_timer
    import drc_pkg::*;
#(
    parameter int WIDTH = TIMER_W
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // Control
    input wire logic i_load,
    input wire logic [WIDTH-1:0] i_value,
    // Status
    output logic o_done
);
    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (i_load) begin
            cnt_nxt = i_value;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - WIDTH'(1);
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Done looks at the count alone: callers feed done back into load, so gating it with load would loop
    assign o_done = (cnt_r == '0);
endmodule : drc_timer

// >>> drc_ctrl_checker.sv
// Assertions on the pins and request port of the RAM controller
module drc_ctrl_checker
    import drc_pkg::*;
#(
    parameter int REFRESH_SWEEP = 4000,
    parameter int STANDBY_LIMIT = 500
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic o_req_ready,
    input wire logic o_rsp_valid,
    input wire logic o_standby,
    input wire logic o_data_trusted,
    input wire logic [ROW_W-1:0] o_row_addr,
    input wire logic [COL_W-1:0] o_col_addr,
    input wire logic o_rw,
    input wire logic o_ce_n,
    input wire logic o_din
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    logic [7:0] lo_cnt_r, lo_cnt_nxt, hi_cnt_r, hi_cnt_nxt;
    logic [ROW_W-1:0] ref_row_r, ref_row_nxt;
    logic rw_q_r;
    int stby_cnt_r, stby_cnt_nxt;
    always_comb begin
        stby_cnt_nxt = !o_standby ? 0 : (stby_cnt_r > STANDBY_LIMIT) ? stby_cnt_r : stby_cnt_r + 1;
        lo_cnt_nxt = o_rw ? 8'h00 : lo_cnt_r + 8'h01;
        hi_cnt_nxt = !o_ce_n ? 8'h00 : (hi_cnt_r == 8'hff) ? 8'hff : hi_cnt_r + 8'h01;
        ref_row_nxt = (rw_q_r && !o_rw && o_ce_n) ? o_row_addr : ref_row_r;
    end
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            lo_cnt_r <= 8'h00;
            hi_cnt_r <= 8'h00;
            ref_row_r <= ROW_LAST;
            rw_q_r <= 1'b1;
            stby_cnt_r <= 0;
        end else begin
            stby_cnt_r <= stby_cnt_nxt;
            lo_cnt_r <= lo_cnt_nxt;
            hi_cnt_r <= hi_cnt_nxt;
            ref_row_r <= ref_row_nxt;
            rw_q_r <= o_rw;
        end
    end
    sequence s_pulse_start;
        $fell(o_rw);
    endsequence
    sequence s_ref_start;
        $fell(o_rw) && o_ce_n;
    endsequence
    a_reset_quiet: assert property ($rose(i_resetn) |-> o_ce_n && o_rw && !o_req_ready && !o_data_trusted)
        else $error("pins not idle after reset");
    // A wait loaded with N holds its state for N+1 cycles
    a_pulse_len: assert property ($rose(o_rw) |-> lo_cnt_r == 8'(WRITE_PULSE_CYC + 1))
        else $error("write pulse length wrong");
    a_addr_setup: assert property (s_pulse_start |-> $past(o_row_addr, 8) == o_row_addr && $past(o_ce_n, 8) == o_ce_n)
        else $error("address or enable not set up before pulse");
    a_pulse_steady: assert property (!o_rw && !$past(o_rw) |-> $stable(o_row_addr) && $stable(o_col_addr) && $stable(o_din) && $stable(o_ce_n))
        else $error("pins moved during write pulse");
    a_refresh_order: assert property (s_ref_start |-> o_row_addr == ROW_W'(ref_row_r + 5'h01) && o_col_addr == 5'h00)
        else $error("refresh row out of order");
    a_read_access: assert property (o_rsp_valid |-> $past(!o_ce_n, READ_ACCESS_CYC) && !$past(o_ce_n))
        else $error("read sampled before access time");
    a_rsp_single: assert property (o_rsp_valid |=> !o_rsp_valid)
        else $error("answer pulse longer than one cycle");
    a_enable_gap: assert property ($fell(o_ce_n) |-> hi_cnt_r >= 8'h2d)
        else $error("enable reasserted inside hold time");
    a_addr_hold: assert property (!o_ce_n && $past(!o_ce_n) |-> $stable(o_row_addr) && $stable(o_col_addr))
        else $error("address moved while enabled");
    a_ready_gate: assert property (o_req_ready |-> o_data_trusted && !o_standby && o_ce_n && o_rw)
        else $error("ready while untrusted or busy");
    a_standby_idle: assert property (o_standby |-> o_ce_n && o_rw)
        else $error("cycle driven during standby");
    a_long_standby: assert property ($fell(o_standby) |-> o_data_trusted == (stby_cnt_r <= STANDBY_LIMIT))
        else $error("trust not matched to standby length");
endmodule : drc_ctrl_checker

// >>> drc_ram_model.sv
// Cycle-based model of the 1024 x 1 dynamic RAM as seen at its pins
module drc_ram_model
    import drc_pkg::*;
#(
    parameter int ACC_CYC = 90,
    parameter int HOLD_CYC = 40,
    parameter int RET_CYC = 8000
) (
    input wire logic i_core_clk,
    input wire logic [ROW_W-1:0] i_row_addr,
    input wire logic [COL_W-1:0] i_col_addr,
    input wire logic i_rw,
    input wire logic i_ce_n,
    input wire logic i_din,
    output logic o_dout
);
    timeunit 1ns;
    timeprecision 1ps;
    logic mem [1024];
    int age [NUM_ROWS];
    int en_cnt = 0;
    int dis_cnt = 0;
    logic last_bit = 1'b0;
    logic [ADDR_W-1:0] idx;
    // Column scramble stands in for the internal column order
    assign idx = {i_row_addr, i_col_addr ^ 5'h0b};
    initial begin
        o_dout = 1'b0;
        foreach (mem[i]) mem[i] = 1'b0;
        foreach (age[i]) age[i] = 0;
    end
    always @(posedge i_core_clk) begin
        foreach (age[i]) age[i] = age[i] + 1;
        if (!i_rw) begin
            age[i_row_addr] = 0;
            if (!i_ce_n) mem[idx] = i_din;
        end
        en_cnt = i_ce_n ? 0 : en_cnt + 1;
        dis_cnt = i_ce_n ? dis_cnt + 1 : 0;
        // A stale row reads back inverted so a missed refresh cannot pass
        if (!i_ce_n && en_cnt >= ACC_CYC) begin
            last_bit = mem[idx] ^ (age[i_row_addr] > RET_CYC);
            o_dout <= last_bit;
        end else if (i_ce_n && dis_cnt <= HOLD_CYC) begin
            o_dout <= last_bit;
        end else begin
            o_dout <= ~o_dout;
        end
    end
endmodule : drc_ram_model

// >>> drc_ctrl_bench.sv
// Self-checking bench for the RAM controller with a device model on its pins
module drc_ctrl_bench
    import drc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, resetn, valid, wdata, wmask, stby;
    drc_cmd_t cmd;
    logic [ADDR_W-1:0] addr;
    logic ready, rsp_valid, rdata, standby, trusted, rw, ce_n, din, dout;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    int fails = 0;
    int checks_done = 0;
    logic shadow [1024];
    logic exp_q [$];
    logic [ADDR_W-1:0] a [16];

    drc_ctrl #(.REFRESH_SWEEP(4000), .STANDBY_LIMIT(500)) DUT (
        .i_core_clk(clk), .i_resetn(resetn), .i_req_valid(valid), .o_req_ready(ready),
        .i_req_cmd(cmd), .i_req_addr(addr), .i_req_wdata(wdata), .i_req_wmask(wmask),
        .o_rsp_valid(rsp_valid), .o_rsp_rdata(rdata), .i_standby_req(stby), .o_standby(standby),
        .o_data_trusted(trusted), .o_row_addr(row), .o_col_addr(col), .o_rw(rw), .o_ce_n(ce_n),
        .o_din(din), .i_dout(dout)
    );
    drc_ram_model u_ram (
        .i_core_clk(clk), .i_row_addr(row), .i_col_addr(col), .i_rw(rw), .i_ce_n(ce_n),
        .i_din(din), .o_dout(dout)
    );

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    task automatic cmp_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %b expected %b", $time, got, exp);
        end
    endtask : cmp_bit

    // 0: ready, 1: ready and all answers in, 2: in standby
    task automatic wait_for(input int w);
        int n = 0;
        while ((w == 2) ? standby !== 1'b1 : (ready !== 1'b1 || (w == 1 && exp_q.size() != 0))) begin
            @(posedge clk);
            #1;
            n++;
            if (n > 6000) begin
                fails++;
                complete_run();
            end
        end
    endtask : wait_for

    // Valid stays up between calls so requests run back to back
    task automatic request(input drc_cmd_t c, input logic [ADDR_W-1:0] ad, input logic d);
        valid = 1'b1;
        cmd = c;
        addr = ad;
        wdata = d;
        wmask = d;
        wait_for(0);
        @(posedge clk);
        #1;
        if (c != DRC_CMD_WRITE) exp_q.push_back(shadow[ad]);
        if (c == DRC_CMD_WRITE) shadow[ad] = d;
        if (c == DRC_CMD_RMW) shadow[ad] = shadow[ad] ^ d;
    endtask : request

    task automatic drain();
        valid = 1'b0;
        wait_for(1);
    endtask : drain

    task automatic read_all();
        for (int i = 0; i < 16; i++) request(DRC_CMD_READ, a[i], 1'b0);
        drain();
    endtask : read_all

    always @(negedge clk) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) cmp_bit(1'b0, 1'b1);
            else cmp_bit(rdata, exp_q.pop_front());
        end
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        {resetn, valid, wdata, wmask, stby, addr} = '0;
        cmd = DRC_CMD_READ;
        void'($urandom(32'ha8380ea6));
        foreach (shadow[i]) shadow[i] = 1'b0;
        foreach (a[i]) a[i] = ADDR_W'($urandom);
        a[0] = 10'h000;
        a[1] = 10'h3ff;
        repeat (10) @(posedge clk);
        #1;
        resetn = 1'b1;
        for (int i = 0; i < 16; i++) begin
            request(DRC_CMD_WRITE, a[i], 1'($urandom));
            request(DRC_CMD_READ, a[i], 1'b0);
        end
        for (int i = 0; i < 8; i++) request(DRC_CMD_RMW, a[i], 1'($urandom));
        read_all();
        // Idle across several sweeps; a missed row would read back inverted
        repeat (12000) @(posedge clk);
        #1;
        cmp_bit(trusted, 1'b1);
        read_all();
        stby = 1'b1;
        wait_for(2);
        repeat (100) @(posedge clk);
        #1;
        cmp_bit(standby, 1'b1);
        stby = 1'b0;
        request(DRC_CMD_READ, a[2], 1'b0);
        drain();
        cmp_bit(trusted, 1'b1);
        stby = 1'b1;
        wait_for(2);
        repeat (600) @(posedge clk);
        #1;
        stby = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        cmp_bit(trusted, 1'b0);
        cmp_bit(ready, 1'b0);
        read_all();
        cmp_bit(trusted, 1'b1);
        complete_run();
    end
endmodule : drc_ctrl_bench

bind drc_ctrl drc_ctrl_checker #(.REFRESH_SWEEP(REFRESH_SWEEP), .STANDBY_LIMIT(STANDBY_LIMIT)) u_chk (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid),
    .o_standby(o_standby), .o_data_trusted(o_data_trusted), .o_row_addr(o_row_addr),
    .o_col_addr(o_col_addr), .o_rw(o_rw), .o_ce_n(o_ce_n), .o_din(o_din)
);
